// ### core/fifo_if.sv
/*
  Valid/ready carrier between the router core and its message queues.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store(input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user(output in_valid, in_data, out_ready,
               input in_ready, out_valid, out_data);
endinterface : fifo_if

// ### core/learning_router.sv
/*
  Learning router core: per-side subnet learning, forwarding decision,
  input, priority and non-priority queues for both directions, service-pin
  rewriting, both-sides error log and the dead state on over-capacity.
  Assumes transceivers on sides 0 and 1 that hand over whole message
  descriptors synchronous to clk, and a configuration size on cfg_buf_bytes.
*/
`timescale 1ns/1ps
`include "router_defines.svh"
module learning_router
  import router_pkg::*;
#(
  parameter int IN_DEPTH = `IN_QUEUE_DEPTH,
  parameter int PRIO_DEPTH = `PRIO_QUEUE_DEPTH,
  parameter int NP_DEPTH = `NP_QUEUE_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Side setup
  input wire logic [1:0][7:0] own_subnet,
  input wire logic [1:0] dual_dom,
  input wire logic [10:0] cfg_buf_bytes,
  // Receive from transceivers
  input wire logic [1:0] rx_valid,
  input wire msg_t [1:0] rx_data,
  output logic [1:0] rx_drop,
  // Local application priority messages
  input wire logic [1:0] app_valid,
  input wire msg_t [1:0] app_data,
  output logic [1:0] app_ready,
  // Transmit to transceivers
  output logic [1:0] tx_valid,
  output msg_t [1:0] tx_data,
  input wire logic [1:0] tx_ready,
  // Error log and health
  output logic err_pulse,
  output logic [7:0] err_count,
  output logic [7:0] err_subnet,
  output logic routing_dead
);
  localparam int MW = $bits(msg_t);

  typedef struct packed {
    logic [1:0][1:0][255:0] flag;
    fwd_state_t [1:0] fst;
    logic [1:0] tx_valid;
    msg_t [1:0] tx_data;
    logic [1:0] app_full;
    msg_t [1:0] app_msg;
    logic [1:0] app_ready;
    logic [1:0] drop;
    logic [7:0] err_count;
    logic [7:0] err_subnet;
    logic err_pulse;
    logic dead;
  } router_state_t;

  router_state_t st;
  router_state_t next_st;
  logic [1:0] rsync;
  logic rstn;

  logic [1:0] in_push;
  logic [1:0] in_ready;
  logic [1:0] in_valid;
  logic [1:0] in_pop;
  msg_t [1:0] in_data;
  logic [1:0] p_push;
  logic [1:0] p_ready;
  logic [1:0] p_valid;
  logic [1:0] p_pop;
  msg_t [1:0] p_data;
  logic [1:0] n_push;
  logic [1:0] n_ready;
  logic [1:0] n_valid;
  logic [1:0] n_pop;
  msg_t [1:0] n_data;
  msg_t [1:0] fwd_msg;
  logic [1:0] bad_msg;
  logic [1:0] fwd_ok;
  logic [1:0] learn_en;
  logic log_ev;
  logic rdy;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rsync <= 2'h0;
    else
      rsync <= {rsync[0], 1'b1};
  end
  assign rstn = rsync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Queues; pushes into side s come from the direction leaving side 1-s
  assign in_push = rx_valid & {2{~st.dead}};

  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_side
      fifo_if #(.W(MW)) iq();
      fifo_if #(.W(MW)) pq();
      fifo_if #(.W(MW)) nq();

      assign iq.in_valid = in_push[s];
      assign iq.in_data = rx_data[s];
      assign iq.out_ready = in_pop[s];
      assign in_ready[s] = iq.in_ready;
      assign in_valid[s] = iq.out_valid;
      assign in_data[s] = iq.out_data;

      assign pq.in_valid = p_push[s];
      assign pq.in_data = fwd_msg[1-s];
      assign pq.out_ready = p_pop[s];
      assign p_ready[s] = pq.in_ready;
      assign p_valid[s] = pq.out_valid;
      assign p_data[s] = pq.out_data;

      assign nq.in_valid = n_push[s];
      assign nq.in_data = fwd_msg[1-s];
      assign nq.out_ready = n_pop[s];
      assign n_ready[s] = nq.in_ready;
      assign n_valid[s] = nq.out_valid;
      assign n_data[s] = nq.out_data;

      // Small input queue keeps priority traffic from waiting long
      msg_fifo #(.W(MW), .DEPTH(IN_DEPTH)) u_in_q (
        .clk(clk),
        .rstn(rstn),
        .q(iq)
      );
      msg_fifo #(.W(MW), .DEPTH(PRIO_DEPTH)) u_prio_q (
        .clk(clk),
        .rstn(rstn),
        .q(pq)
      );
      msg_fifo #(.W(MW), .DEPTH(NP_DEPTH)) u_np_q (
        .clk(clk),
        .rstn(rstn),
        .q(nq)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding engines, learning tables and transmit selection
  always_comb
  begin
    next_st = st;
    next_st.err_pulse = 1'b0;
    next_st.drop = rx_valid & ~in_ready & {2{~st.dead}};
    in_pop = 2'h0;
    p_push = 2'h0;
    n_push = 2'h0;
    p_pop = 2'h0;
    n_pop = 2'h0;
    fwd_msg = in_data;
    bad_msg = 2'h0;
    fwd_ok = 2'h0;
    learn_en = 2'h0;
    log_ev = 1'b0;
    rdy = 1'b0;
    // Latched for good: only a full reset brings the router back
    if (cfg_buf_bytes > `BUF_SPACE_BYTES)
      next_st.dead = 1'b1;
    for (int d = 0; d < 2; d++)
    begin
      if (in_data[d].svc_pin && in_data[d].src == `SUBNET_NONE)
        fwd_msg[d].src = own_subnet[d];
      if (st.fst[d] == FWD_COPY)
        fwd_msg[d].dom = ~in_data[d].dom;
      // Our own stamp coming back means the copy went round a loop
      bad_msg[d] = !in_data[d].crc_ok ||
                   (in_data[d].len > `NET_BUF_BYTES) ||
                   (in_data[d].svc_pin &&
                    in_data[d].src == own_subnet[d]);
      fwd_ok[d] = in_data[d].group || in_data[d].svc_pin ||
                  (st.flag[d][in_data[d].dom][in_data[d].dst] &&
                   in_data[d].dst != in_data[d].src);
      rdy = in_data[d].prio ? p_ready[1-d] : n_ready[1-d];
      case (st.fst[d])
        FWD_RUN:
          if (in_valid[d])
          begin
            if (bad_msg[d] || !fwd_ok[d])
            begin
              in_pop[d] = 1'b1;
              learn_en[d] = !bad_msg[d];
              next_st.drop[d] = next_st.drop[d] | bad_msg[d];
            end
            else if (rdy)
            begin
              learn_en[d] = 1'b1;
              p_push[1-d] = in_data[d].prio;
              n_push[1-d] = !in_data[d].prio;
              if (in_data[d].svc_pin && dual_dom[d])
                next_st.fst[d] = FWD_COPY;
              else
                in_pop[d] = 1'b1;
            end
          end
        FWD_COPY:
          if (rdy)
          begin
            p_push[1-d] = in_data[d].prio;
            n_push[1-d] = !in_data[d].prio;
            in_pop[d] = 1'b1;
            next_st.fst[d] = FWD_RUN;
          end
        default:
          in_pop[d] = in_valid[d];
      endcase
      if (st.dead)
        next_st.fst[d] = FWD_DEAD;
      // Table indexed by side, domain and subnet
      if (learn_en[d] && in_data[d].src != `SUBNET_NONE &&
          st.flag[d][in_data[d].dom][in_data[d].src])
      begin
        next_st.flag[d][in_data[d].dom][in_data[d].src] = 1'b0;
        if (!st.flag[1-d][in_data[d].dom][in_data[d].src])
        begin
          log_ev = 1'b1;
          next_st.err_subnet = in_data[d].src;
        end
      end
    end
    if (log_ev)
    begin
      next_st.err_pulse = 1'b1;
      if (st.err_count != `ERR_COUNT_MAX)
        next_st.err_count = st.err_count + 8'h01;
    end
    for (int s = 0; s < 2; s++)
    begin
      if (!st.tx_valid[s] || tx_ready[s])
      begin
        next_st.tx_valid[s] = 1'b0;
        if (p_valid[s])
        begin
          next_st.tx_valid[s] = 1'b1;
          next_st.tx_data[s] = p_data[s];
          p_pop[s] = 1'b1;
        end
        else if (st.app_full[s])
        begin
          next_st.tx_valid[s] = 1'b1;
          next_st.tx_data[s] = st.app_msg[s];
          next_st.app_full[s] = 1'b0;
        end
        else if (n_valid[s])
        begin
          next_st.tx_valid[s] = 1'b1;
          next_st.tx_data[s] = n_data[s];
          n_pop[s] = 1'b1;
        end
      end
      // Oversized application messages are taken and discarded
      if (app_valid[s] && st.app_ready[s] &&
          app_data[s].len <= `APP_BUF_BYTES)
      begin
        next_st.app_full[s] = 1'b1;
        next_st.app_msg[s] = app_data[s];
      end
      next_st.app_ready[s] = !next_st.app_full[s] && !next_st.dead;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.flag <= {1024{`FLAG_PERMIT}};
    end
    else
      st <= next_st;
  end

  assign rx_drop = st.drop;
  assign app_ready = st.app_ready;
  assign tx_valid = st.tx_valid;
  assign tx_data = st.tx_data;
  assign err_pulse = st.err_pulse;
  assign err_count = st.err_count;
  assign err_subnet = st.err_subnet;
  assign routing_dead = st.dead;

  ////////////////////////////////////////////////////////////////////////////
  // Checks, direction 0 stands for both
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_flags_restart: assert property ($rose(rstn) |-> &st.flag)
    else $error("flags not all permitting after reset");
  chk_learn_clear: assert property (
    (learn_en[0] && in_data[0].src != `SUBNET_NONE) |=>
      !st.flag[0][$past(in_data[0].dom)][$past(in_data[0].src)])
    else $error("source subnet not learned");
  chk_local_drop: assert property (
    (st.fst[0] == FWD_RUN && in_valid[0] && !fwd_ok[0]) |->
      (p_push[1] == 1'b0 && n_push[1] == 1'b0 && in_pop[0]))
    else $error("local message forwarded");
  chk_group_pass: assert property (
    (st.fst[0] == FWD_RUN && in_valid[0] && in_data[0].group &&
     !bad_msg[0] && !st.dead && n_ready[1] && p_ready[1]) |->
      (p_push[1] || n_push[1]))
    else $error("group message not forwarded");
  chk_both_sides: assert property (
    (log_ev && st.err_count != `ERR_COUNT_MAX) |=>
      (st.err_pulse && st.err_count == $past(st.err_count) + 8'h01))
    else $error("both-sides subnet not logged");
  chk_svc_stamp: assert property (
    ((p_push[1] || n_push[1]) && in_data[0].svc_pin &&
     in_data[0].src == `SUBNET_NONE) |-> fwd_msg[0].src == own_subnet[0])
    else $error("service-pin source not rewritten");
  chk_svc_copies: assert property (
    (st.fst[0] == FWD_RUN && n_push[1] && in_data[0].svc_pin &&
     dual_dom[0] && !st.dead) |=> st.fst[0] == FWD_COPY ##1 1'b1)
    else $error("second domain copy missing");
  chk_loop_drop: assert property (
    (in_valid[0] && in_data[0].svc_pin &&
     in_data[0].src == own_subnet[0]) |-> !(p_push[1] || n_push[1]))
    else $error("looped service-pin copy forwarded");
  chk_prio_first: assert property (n_pop[0] |-> !p_valid[0])
    else $error("non-priority sent while priority waits");
  chk_overflow_drop: assert property (
    (rx_valid[0] && !in_ready[0] && !st.dead) |=> st.drop[0])
    else $error("input overflow not flagged");
  chk_dead_stays: assert property (
    st.dead |=> (st.dead && st.fst == {FWD_DEAD, FWD_DEAD} &&
                 !(|p_push) && !(|n_push)) [*2])
    else $error("routing resumed after dead state");
  chk_app_limit: assert property (
    (app_valid[0] && st.app_ready[0] &&
     app_data[0].len > `APP_BUF_BYTES) |=> !st.app_full[0])
    else $error("oversized application message buffered");

  cov_group_fwd: cover property (n_push[1] && in_data[0].group);
  cov_err_log: cover property (log_ev);
  cov_svc_copy: cover property (st.fst[0] == FWD_COPY ##1 in_pop[0]);
  cov_prio_tx: cover property (p_pop[1] ##1 n_pop[1]);

endmodule : learning_router

// ### core/msg_fifo.sv
/*
  Message queue of parameter width and depth, valid/ready on both sides.
  Assumes a synchronised active-low reset from the router top.
*/
`timescale 1ns/1ps
module msg_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Queue
  fifo_if.store q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign push = q.in_valid && q.in_ready;
  assign pop = q.out_valid && q.out_ready;
  assign q.in_ready = st.cnt != CW'(DEPTH);
  assign q.out_valid = st.cnt != '0;
  assign q.out_data = st.mem[st.rp];

  // Pointers wrap at DEPTH so depths need not be powers of two
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = q.in_data;
      next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : msg_fifo

// ### core/router_defines.svh
/*
  Constants for the two-sided learning router: byte limits, queue depths,
  reset values and special subnet codes.
  Assumes inclusion by bare name from the design files.
*/
// How it works
// - After initialisation every subnet flag permits forwarding to the far side.
// - A newly seen source subnet clears its flag in the receiving side's table.
// - The destination subnet flag, after learning, decides forward or discard.
// - Every reset discards all learned subnet locations; learning starts over.
// - A subnet cleared on both sides is detected and recorded in an error log; not logged when both sides clear it in the same cycle.
// - Group-addressed messages are always forwarded while learning.
// - Service-pin source rewriting lets looped copies be recognised and discarded.
// - Every received message enters the receiving side's input queue first.
// - The input queue holds two messages by default.
// - Priority output queue drains fully before the non-priority queue sends.
// - Each direction has its own input, priority and non-priority queues.
// - Two priority network output buffers of 66 bytes per side.
// - One priority application output buffer of 42 bytes per side.
// - Over-capacity configuration leaves the router dead, routing stopped for good.
// - Service-pin source subnet zero becomes own subnet; one copy per domain.
// - Only valid-CRC messages that fit the buffers are forwarded; others dropped.
// - Each side keeps per-domain flags for 255 subnets; groups have no flags.
`ifndef ROUTER_DEFINES_SVH
`define ROUTER_DEFINES_SVH

`define NET_BUF_BYTES 8'h42
`define APP_BUF_BYTES 8'h2A
`define BUF_SPACE_BYTES 11'h57D
`define IN_QUEUE_DEPTH 2
`define PRIO_QUEUE_DEPTH 2
`define NP_QUEUE_DEPTH 32
`define FLAG_PERMIT 1'b1
`define SUBNET_NONE 8'h00
`define ERR_COUNT_MAX 8'hFF

`endif

// ### core/router_pkg.sv
/*
  Types shared by the router core: message descriptor and engine states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package router_pkg;

  // One message descriptor as handed over by a transceiver
  typedef struct packed {
    logic prio;
    logic crc_ok;
    logic group;
    logic svc_pin;
    logic dom;
    logic [7:0] src;
    logic [7:0] dst;
    logic [7:0] len;
  } msg_t;

  typedef enum logic [1:0] {
    FWD_RUN = 2'h0,
    FWD_COPY = 2'h1,
    FWD_DEAD = 2'h3
  } fwd_state_t;

endpackage : router_pkg

// ### verif/tb_top.sv
/*
  Self-checking bench for the learning router core: a queue model
  predicts every transmitted descriptor, drop and error event.
  Assumes the core with a small non-priority depth of 4.
*/
`timescale 1ns/1ps
module tb_top
  import router_pkg::*;
;
  logic clk, nrst, err_pulse, routing_dead;
  logic [1:0][7:0] own_subnet;
  logic [1:0] dual_dom, rx_valid, rx_drop, app_valid, app_ready;
  logic [1:0] tx_valid, tx_ready, stall, slow;
  logic [10:0] cfg_buf_bytes;
  logic [7:0] err_count, err_subnet;
  msg_t [1:0] rx_data, app_data, tx_data;
  msg_t m;
  int n_fail, n_checks, seed, nerr, i, k;
  int ndrop[2], xdrop[2];
  bit dead;
  bit fl[2][2][256];
  msg_t cq[2][$], pq[2][$], nq[2][$];
  logic [7:0] xerr[$];

  learning_router #(.NP_DEPTH(4)) dut_u (.clk(clk), .nrst(nrst),
    .own_subnet(own_subnet), .dual_dom(dual_dom),
    .cfg_buf_bytes(cfg_buf_bytes), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_drop(rx_drop), .app_valid(app_valid),
    .app_data(app_data), .app_ready(app_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .err_pulse(err_pulse),
    .err_count(err_count), .err_subnet(err_subnet),
    .routing_dead(routing_dead));
  xcvr_model p0 (.clk(clk), .stall(stall[0]), .slow(slow[0]),
    .tx_valid(tx_valid[0]), .tx_data(tx_data[0]), .tx_ready(tx_ready[0]));
  xcvr_model p1 (.clk(clk), .stall(stall[1]), .slow(slow[1]),
    .tx_valid(tx_valid[1]), .tx_data(tx_data[1]), .tx_ready(tx_ready[1]));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task push(input int d, input msg_t c);
    if (c.prio)
      pq[d].push_back(c);
    else
      nq[d].push_back(c);
  endtask : push

  // Queue model of one forwarding decision
  task automatic route(input int d, input msg_t m);
    msg_t c;
    bit pre;
    c = m;
    if (dead)
      return;
    if (!m.crc_ok || m.len > 8'h42 || (m.svc_pin && m.src == own_subnet[d]))
    begin
      xdrop[d]++;
      return;
    end
    pre = fl[d][m.dom][m.dst] && m.dst != m.src;
    // Logged only when the second side's flag newly clears
    if (m.src != 8'h00 && fl[d][m.dom][m.src])
    begin
      if (!fl[1-d][m.dom][m.src])
      begin
        xerr.push_back(m.src);
        nerr++;
      end
      fl[d][m.dom][m.src] = 1'b0;
    end
    if (!(m.group || m.svc_pin || pre))
      return;
    if (m.svc_pin && m.src == 8'h00)
      c.src = own_subnet[d];
    push(1 - d, c);
    if (m.svc_pin && dual_dom[d])
    begin
      c.dom = ~c.dom;
      push(1 - d, c);
    end
  endtask : route

  function automatic logic [31:0] nxt(int d);
    if (cq[d].size() > 0)
      return {3'h0, cq[d].pop_front()};
    if (pq[d].size() > 0)
      return {3'h0, pq[d].pop_front()};
    if (nq[d].size() > 0)
      return {3'h0, nq[d].pop_front()};
    return 32'hFFFFFFFF;
  endfunction : nxt

  function automatic msg_t mk(bit p, bit g, bit v, logic [7:0] a,
                              logic [7:0] b);
    return '{prio:p, crc_ok:1'b1, group:g, svc_pin:v, dom:1'b0, src:a,
             dst:b, len:8'($random(seed) & 63)};
  endfunction : mk

  always @(posedge clk)
    if (nrst)
    begin
      for (int d = 0; d < 2; d++)
      begin
        if (tx_valid[d] && tx_ready[d])
          chk({3'h0, tx_data[d]}, nxt(d));
        if (rx_drop[d])
          ndrop[d]++;
      end
      if (err_pulse)
        chk(err_subnet, xerr.size() ? xerr.pop_front() : 32'h1FF);
    end

  ////////////////////////////////////////////////////////////////////////
  task send(input int d, input msg_t v, input bit last);
    @(negedge clk);
    rx_valid[d] = 1'b1;
    rx_data[d] = v;
    route(d, v);
    if (last)
    begin
      @(negedge clk);
      rx_valid[d] = 1'b0;
    end
  endtask : send

  task stuck;
    n_fail++;
    $display("unexpected at %0t: wait ran out %h %h", $time, 0, 1);
    close_out();
  endtask : stuck

  task drain(input string name);
    for (k = 0; k < 400 && cq[0].size() + cq[1].size() + pq[0].size() +
         pq[1].size() + nq[0].size() + nq[1].size() > 0; k++)
      @(negedge clk);
    if (k == 400)
      stuck();
    repeat (6) @(negedge clk);
    chk(ndrop[0], xdrop[0]);
    chk(ndrop[1], xdrop[1]);
    chk(err_count, nerr);
    $display("test %s done", name);
  endtask : drain

  task do_reset;
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    foreach (fl[a, b, c])
      fl[a][b][c] = 1'b1;
    for (int d = 0; d < 2; d++)
    begin
      cq[d].delete();
      pq[d].delete();
      nq[d].delete();
      ndrop[d] = 0;
      xdrop[d] = 0;
    end
    nerr = 0;
    xerr.delete();
    nrst = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #4000000;
    stuck();
  end

  initial
  begin
    {n_fail, n_checks, nerr} = 0;
    seed = 8859;
    dead = 1'b0;
    nrst = 1'b0;
    rx_valid = 2'h0;
    rx_data = '0;
    app_valid = 2'h0;
    app_data = '0;
    own_subnet = {8'h22, 8'h11};
    dual_dom = 2'h3;
    cfg_buf_bytes = 11'h57D;
    stall = 2'h0;
    slow = 2'h0;
    do_reset();
    send(0, mk(0, 0, 0, 8'h05, 8'h09), 1);
    send(0, mk(0, 0, 0, 8'h07, 8'h05), 1);
    send(0, mk(0, 1, 0, 8'h07, 8'h05), 1);
    send(1, mk(0, 0, 0, 8'h09, 8'h05), 1);
    send(1, mk(0, 0, 0, 8'h05, 8'h07), 1);
    drain("learning");
    m = mk(0, 0, 0, 8'h03, 8'h09);
    m.crc_ok = 1'b0;
    send(0, m, 1);
    m.crc_ok = 1'b1;
    m.len = 8'h43;
    send(0, m, 1);
    m.len = 8'h42;
    send(0, m, 1);
    send(1, mk(0, 0, 1, 8'h00, 8'hFF), 1);
    send(0, mk(0, 0, 1, 8'h00, 8'hFE), 1);
    send(0, mk(0, 0, 1, 8'h11, 8'hFF), 1);
    drain("filter");
    stall[1] = 1'b1;
    send(0, mk(0, 1, 0, 8'h00, 8'h01), 1);
    for (k = 0; k < 20 && !tx_valid[1]; k++)
      @(negedge clk);
    if (k == 20)
      stuck();
    cq[1].push_back(nq[1].pop_front());
    send(0, mk(0, 1, 0, 8'h00, 8'h02), 1);
    send(0, mk(1, 1, 0, 8'h00, 8'h03), 1);
    // Both queued before the stall lifts
    repeat (2) @(negedge clk);
    stall[1] = 1'b0;
    drain("priority");
    slow = 2'h3;
    for (i = 0; i < 24; i++)
    begin
      m = mk($random(seed), $random(seed), 0, 8'($random(seed) & 15),
             8'($random(seed) & 15));
      send(i % 2, m, 1);
      repeat (4) @(negedge clk);
    end
    slow = 2'h0;
    drain("random");
    stall[1] = 1'b1;
    for (i = 0; i < 10; i++)
      send(0, mk(0, 1, 0, 8'h00, 8'(i)), i == 9);
    repeat (6) @(negedge clk);
    // Held: tx register, four queued, two in the input queue
    chk(ndrop[0] - xdrop[0], 3);
    while (nq[1].size() > 7)
      void'(nq[1].pop_back());
    xdrop[0] += 3;
    stall[1] = 1'b0;
    drain("overflow");
    for (i = 0; i < 2; i++)
    begin
      for (k = 0; k < 20 && !app_ready[0]; k++)
        @(negedge clk);
      if (k == 20)
        stuck();
      m = mk(1, 0, 0, 8'h11, 8'h30);
      m.len = 8'h2A + 8'(i);
      app_valid[0] = 1'b1;
      app_data[0] = m;
      if (i == 0)
        cq[0].push_back(m);
      @(negedge clk);
      app_valid[0] = 1'b0;
    end
    drain("app");
    do_reset();
    chk(err_count, 0);
    send(0, mk(0, 0, 0, 8'h07, 8'h05), 1);
    drain("reset");
    cfg_buf_bytes = 11'h57E;
    repeat (3) @(negedge clk);
    chk(routing_dead, 1);
    chk(app_ready[0], 0);
    dead = 1'b1;
    send(0, mk(0, 1, 0, 8'h00, 8'h05), 1);
    drain("dead");
    close_out();
  end
endmodule : tb_top

// ### verif/xcvr_model.sv
/*
  Transceiver model on one router side: takes transmitted descriptors,
  promptly, slowly (one edge in four) or not at all while stalled.
  Assumes one clock; the bench drives stall and slow.
*/
`timescale 1ns/1ps
module xcvr_model
  import router_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pace set by the bench
  input wire logic stall,
  input wire logic slow,
  // Router transmit side
  input wire logic tx_valid,
  input wire msg_t tx_data,
  output logic tx_ready
);
  logic [1:0] ph;
  int n_taken;

  initial
  begin
    tx_ready = 1'b0;
    ph = 2'h0;
    n_taken = 0;
  end

  // Ready moves only off the sampling edge
  always @(negedge clk)
  begin
    ph <= ph + 2'h1;
    tx_ready <= !stall && (!slow || ph == 2'h0);
  end

  always @(posedge clk)
    if (tx_valid && tx_ready)
      n_taken++;
endmodule : xcvr_model
